// ===== uart_flow_pkg.sv
package uart_flow_pkg;
   // register byte addresses
   localparam logic [7:0] OFF_IER = 8'h04;
   localparam logic [7:0] OFF_IIR = 8'h08;
   localparam logic [7:0] OFF_FCR = 8'h0c;
   localparam logic [7:0] OFF_LCR = 8'h10;
   localparam logic [7:0] OFF_MCR = 8'h14;
   localparam logic [7:0] OFF_LSR = 8'h18;
   localparam logic [7:0] OFF_MSR = 8'h1c;
   localparam logic [7:0] OFF_SPR = 8'h20;
   localparam logic [7:0] OFF_DLL = 8'h24;
   localparam logic [7:0] OFF_DLH = 8'h28;
   localparam logic [7:0] OFF_EFR = 8'h2c;
   localparam logic [7:0] OFF_RES1 = 8'h30;
   localparam logic [7:0] OFF_RES2 = 8'h34;
   localparam logic [7:0] OFF_STOP1 = 8'h38;
   localparam logic [7:0] OFF_STOP2 = 8'h3c;
   localparam logic [7:0] OFF_TCR = 8'h40;
   localparam logic [7:0] OFF_TLR = 8'h44;
   // reset values, and the ident code read while the stop flag is set
   localparam logic [7:0] IIR_RST = 8'h01;
   localparam logic [7:0] LCR_RST = 8'h1d;
   localparam logic [7:0] LSR_RST = 8'h60;
   localparam logic [7:0] IIR_XOFF_CODE = 8'h10;
   // field positions
   localparam int EFR_AUTO_CTS = 7;
   localparam int EFR_SPECIAL = 5;
   localparam int MCR_XON_ANY = 5;
   localparam int MCR_RTS = 1;
   localparam int MCR_DTR = 0;
   localparam int IER_XOFF = 5;
   localparam int LCR_STOP2 = 2;
   localparam int LCR_PAR_EN = 3;
   localparam int LCR_EVEN = 4;
   localparam int LCR_BREAK = 6;
   // thresholds count in steps of four characters
   localparam int THR_SHIFT = 2;
   // clock cycles per serial bit
   localparam int BIT_CYC = 16;

   typedef struct packed {
      logic err;
      logic [7:0] data;
   } rx_char_t;
endpackage : uart_flow_pkg

// ===== uart_flow_ctl.sv
// Operation
// RULE1 - two feature bits enable automatic CTS gating and automatic RTS separately; the code has auto CTS (bit 7) only, rts_n follows the modem control RTS bit
// RULE2 - with auto CTS, start each new character only while CTS is low
// RULE3 - CTS rising mid-character finishes that character and withholds the next
// RULE4 - CTS returning low lets queued transmit data flow again
// RULE5 - upper select bits choose transmitted flow characters: none, pair one, two, both
// RULE6 - lower select bits choose receive compare; 11 means either or sequential pairs
// RULE7 - any-character resume bit: any received character after a stop resumes
// RULE8 - special character matching stop two flags, stores, clears on ident read
// RULE9 - received stop halts after current character, sets flag, drives interrupt
// RULE10 - received resume characters clear the flag and restart transmission
// RULE11 - flow character with parity, framing or break error is ordinary data
// RULE12 - send stop characters once receive level passes the halt threshold
// RULE13 - after a stop, send resume characters when level falls to resume threshold
// RULE14 - disabling or changing flow mode after a stop sends the original resume
// RULE15 - unmatched first character of a sequential pair is stored as data
// RULE16 - flow characters framed like data, only word-length low bits sent
// RULE17 - software never enables hardware and software flow control together
// RULE18 - reset clears enable, fifo control, thresholds, trigger; ident 01, line 1d
// RULE19 - reset clears modem control and feature bits 6..0, bit 7 inverse prescale pin
// RULE20 - reset line status 60, modem status low deltas cleared, pointers cleared
// RULE21 - reset keeps divisors, scratchpad and the four flow characters
// RULE22 - reset drives serial out, RTS, DTR, receive ready high; transmit ready low
// RULE23 - each flow character is a full byte register compared on all bits
`timescale 1ns/1ns
module uart_flow_ctl
   import uart_flow_pkg::*;
#(
   parameter int LVL_W = 7,
   parameter int BIT_CYCLES = BIT_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transmit fifo head
   input wire logic txf_valid,
   input wire logic [7:0] txf_data,
   input wire logic txf_full,
   output logic txf_take,
   // received characters and receive fifo
   input wire logic rxc_valid,
   input wire rx_char_t rxc,
   input wire logic [LVL_W-1:0] rx_level,
   output logic rxw_valid,
   output rx_char_t rxw,
   // pins
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic cd_n,
   input wire logic prescale_select_pin,
   output logic tx_out,
   output logic rts_n,
   output logic dtr_n,
   output logic receive_ready_out_n,
   output logic transmit_ready_out_n,
   output logic int_out
);
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;

   logic [7:0] interrupt_enable_reg_r, fifo_control_reg_r, line_control_reg_r;
   logic [7:0] modem_control_reg_r, enhanced_feature_reg_r;
   logic [7:0] flow_threshold_reg_r, trigger_level_reg_r, line_status_reg_r;
   logic [7:0] scratchpad_reg_r, divisor_low_byte_r, divisor_high_byte_r;
   logic [7:0] resume_char_one_r, resume_char_two_r, stop_char_one_r, stop_char_two_r;
   logic [3:0] msr_delta_r, modem_prev_r;
   logic [31:0] prdata_r, rd_nxt;
   logic pready_r, pslverr_r, hit;
   logic wr_done, rd_done, iir_rd, msr_rd;

   tx_state_t state_r;
   logic [15:0] cyc_r;
   logic [2:0] idx_r;
   logic [7:0] shift_r;
   logic line_r, par_r, stop_two_r, tx_out_r, txf_take_r;
   logic cts_ok, bit_end, flow_load;

   logic flow_busy_r, flow_res_r, flow_second_r, xoff_sent_r;
   logic [1:0] flow_sel_r, sent_sel_r;
   logic [LVL_W-1:0] halt_lvl, res_lvl;

   logic halted_r, flag_r, flag_special_r;
   logic pend_r, pend_stop_r, hold_v_r;
   rx_char_t pend_c_r, hold_c_r, in_c, rxw_r;
   logic rxw_valid_r, in_v, ok, seq, stop_hit, res_hit;
   logic m_s1, m_s2, m_r1, m_r2;
   logic [1:0] rsel, tsel;
   logic rts_n_r, dtr_n_r, rx_rdy_n_r, tx_rdy_n_r, int_out_r;

   // apb: one wait state, answer comes from flops
   assign wr_done = psel && penable && pready_r && pwrite;
   assign rd_done = psel && penable && pready_r && !pwrite;
   assign iir_rd = rd_done && paddr == OFF_IIR;
   assign msr_rd = rd_done && paddr == OFF_MSR;

   always_comb
   begin
      hit = 1'b1;
      rd_nxt = 32'h0000_0000;
      case (paddr)
         OFF_IER: rd_nxt[7:0] = interrupt_enable_reg_r;
         OFF_IIR: rd_nxt[7:0] = flag_r ? IIR_XOFF_CODE : IIR_RST;
         OFF_FCR: rd_nxt[7:0] = fifo_control_reg_r;
         OFF_LCR: rd_nxt[7:0] = line_control_reg_r;
         OFF_MCR: rd_nxt[7:0] = modem_control_reg_r;
         OFF_LSR: rd_nxt[7:0] = line_status_reg_r;
         OFF_MSR: rd_nxt[7:0] = {~cd_n, ~ri_n, ~dsr_n, ~cts_n, msr_delta_r};
         OFF_SPR: rd_nxt[7:0] = scratchpad_reg_r;
         OFF_DLL: rd_nxt[7:0] = divisor_low_byte_r;
         OFF_DLH: rd_nxt[7:0] = divisor_high_byte_r;
         OFF_EFR: rd_nxt[7:0] = enhanced_feature_reg_r;
         OFF_RES1: rd_nxt[7:0] = resume_char_one_r;
         OFF_RES2: rd_nxt[7:0] = resume_char_two_r;
         OFF_STOP1: rd_nxt[7:0] = stop_char_one_r;
         OFF_STOP2: rd_nxt[7:0] = stop_char_two_r;
         OFF_TCR: rd_nxt[7:0] = flow_threshold_reg_r;
         OFF_TLR: rd_nxt[7:0] = trigger_level_reg_r;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !hit;
         prdata_r <= (psel && penable && !pready_r && !pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end

   // RULE18 RULE19 reset values
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         interrupt_enable_reg_r <= 8'h00;
         fifo_control_reg_r <= 8'h00;
         line_control_reg_r <= LCR_RST;
         flow_threshold_reg_r <= 8'h00;
         trigger_level_reg_r <= 8'h00;
         modem_control_reg_r <= {~prescale_select_pin, 7'h00};
         enhanced_feature_reg_r <= {~prescale_select_pin, 7'h00};
      end
      else if (wr_done)
      begin
         case (paddr)
            OFF_IER: interrupt_enable_reg_r <= pwdata[7:0];
            OFF_FCR: fifo_control_reg_r <= pwdata[7:0];
            OFF_LCR: line_control_reg_r <= pwdata[7:0];
            OFF_MCR: modem_control_reg_r <= pwdata[7:0];
            OFF_EFR: enhanced_feature_reg_r <= pwdata[7:0];
            OFF_TCR: flow_threshold_reg_r <= pwdata[7:0];
            OFF_TLR: trigger_level_reg_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // RULE21 RULE23 retained through reset
   always_ff @(posedge clk)
   begin
      if (wr_done)
      begin
         case (paddr)
            OFF_SPR: scratchpad_reg_r <= pwdata[7:0];
            OFF_DLL: divisor_low_byte_r <= pwdata[7:0];
            OFF_DLH: divisor_high_byte_r <= pwdata[7:0];
            OFF_RES1: resume_char_one_r <= pwdata[7:0];
            OFF_RES2: resume_char_two_r <= pwdata[7:0];
            OFF_STOP1: stop_char_one_r <= pwdata[7:0];
            OFF_STOP2: stop_char_two_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // RULE20 status after reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         line_status_reg_r <= LSR_RST;
         msr_delta_r <= 4'h0;
         // no false delta from pins already low
         modem_prev_r <= {cd_n, ri_n, dsr_n, cts_n};
      end
      else
      begin
         line_status_reg_r <= {1'b0, state_r == TX_IDLE && !txf_valid, !txf_valid, 4'h0,
            rx_level != '0};
         modem_prev_r <= {cd_n, ri_n, dsr_n, cts_n};
         // a change seen during the read still sets its delta
         msr_delta_r <= (msr_rd ? 4'h0 : msr_delta_r)
            | (modem_prev_r ^ {cd_n, ri_n, dsr_n, cts_n});
      end
   end

   // RULE1 RULE2 RULE4 auto cts only checked at character start
   assign cts_ok = !enhanced_feature_reg_r[EFR_AUTO_CTS] || !cts_n;
   assign bit_end = cyc_r == 16'(BIT_CYCLES - 1);
   assign flow_load = state_r == TX_IDLE && flow_busy_r && cts_ok;

   // RULE5 pair one for 10, pair two for 01, one then two for 11
   function automatic logic [7:0] flow_char(input logic res, input logic [1:0] sel,
      input logic second, input logic [7:0] r1, input logic [7:0] r2,
      input logic [7:0] s1, input logic [7:0] s2);
      logic use_two;
      use_two = sel == 2'b01 || second;
      if (res)
         flow_char = use_two ? r2 : r1;
      else
         flow_char = use_two ? s2 : s1;
   endfunction : flow_char

   // RULE3 RULE16 serializer; flow characters share data framing
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= TX_IDLE;
         line_r <= 1'b1;
         cyc_r <= 16'h0000;
         idx_r <= 3'h0;
         shift_r <= 8'h00;
         par_r <= 1'b0;
         stop_two_r <= 1'b0;
         txf_take_r <= 1'b0;
      end
      else
      begin
         txf_take_r <= 1'b0;
         cyc_r <= bit_end ? 16'h0000 : cyc_r + 16'h0001;
         case (state_r)
            TX_IDLE:
            begin
               cyc_r <= 16'h0000;
               if (flow_load || (txf_valid && !halted_r && cts_ok))
               begin
                  shift_r <= flow_load ? flow_char(flow_res_r, flow_sel_r, flow_second_r,
                     resume_char_one_r, resume_char_two_r, stop_char_one_r, stop_char_two_r)
                     : txf_data;
                  txf_take_r <= !flow_load;
                  par_r <= !line_control_reg_r[LCR_EVEN];
                  // wraps to 0 as bit 0 goes out
                  idx_r <= 3'h7;
                  line_r <= 1'b0;
                  state_r <= TX_START;
               end
            end
            TX_START, TX_DATA:
               if (bit_end)
               begin
                  line_r <= shift_r[0];
                  par_r <= par_r ^ shift_r[0];
                  shift_r <= {1'b0, shift_r[7:1]};
                  state_r <= TX_DATA;
                  idx_r <= idx_r + 3'h1;
                  if (state_r == TX_DATA && idx_r == {1'b1, line_control_reg_r[1:0]})
                  begin
                     line_r <= line_control_reg_r[LCR_PAR_EN] ? par_r : 1'b1;
                     state_r <= line_control_reg_r[LCR_PAR_EN] ? TX_PAR : TX_STOP;
                     stop_two_r <= line_control_reg_r[LCR_STOP2];
                  end
               end
            TX_PAR:
               if (bit_end)
               begin
                  line_r <= 1'b1;
                  state_r <= TX_STOP;
               end
            TX_STOP:
               if (bit_end)
               begin
                  stop_two_r <= 1'b0;
                  if (!stop_two_r)
                     state_r <= TX_IDLE;
               end
            default: state_r <= TX_IDLE;
         endcase
      end
   end

   // RULE12 RULE13 thresholds in units of four characters
   assign halt_lvl = LVL_W'({flow_threshold_reg_r[3:0], 2'b00});
   assign res_lvl = LVL_W'({flow_threshold_reg_r[7:4], 2'b00});
   assign tsel = enhanced_feature_reg_r[3:2];
   assign rsel = enhanced_feature_reg_r[1:0];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flow_busy_r <= 1'b0;
         flow_res_r <= 1'b0;
         flow_second_r <= 1'b0;
         flow_sel_r <= 2'b00;
         xoff_sent_r <= 1'b0;
         sent_sel_r <= 2'b00;
      end
      else if (flow_busy_r)
      begin
         if (flow_load)
         begin
            flow_second_r <= flow_sel_r == 2'b11 && !flow_second_r;
            flow_busy_r <= flow_sel_r == 2'b11 && !flow_second_r;
         end
      end
      // RULE13 RULE14 resume uses the selection the stop went out with
      else if (xoff_sent_r && (tsel != sent_sel_r || rx_level <= res_lvl))
      begin
         flow_busy_r <= 1'b1;
         flow_res_r <= 1'b1;
         flow_sel_r <= sent_sel_r;
         flow_second_r <= 1'b0;
         xoff_sent_r <= 1'b0;
      end
      // RULE12 stop characters
      else if (!xoff_sent_r && tsel != 2'b00 && rx_level > halt_lvl)
      begin
         flow_busy_r <= 1'b1;
         flow_res_r <= 1'b0;
         flow_sel_r <= tsel;
         flow_second_r <= 1'b0;
         xoff_sent_r <= 1'b1;
         sent_sel_r <= tsel;
      end
   end

   // receive compare; a held char is replayed the cycle after a pair breaks
   assign in_v = hold_v_r || rxc_valid;
   assign in_c = hold_v_r ? hold_c_r : rxc;
   // RULE11 erroneous characters never match
   assign ok = !in_c.err;
   // RULE23 full byte compare
   assign m_s1 = in_c.data == stop_char_one_r;
   assign m_s2 = in_c.data == stop_char_two_r;
   assign m_r1 = in_c.data == resume_char_one_r;
   assign m_r2 = in_c.data == resume_char_two_r;
   // RULE6 sequential pairs when transmit uses both or none
   assign seq = rsel == 2'b11 && (tsel == 2'b11 || tsel == 2'b00);
   assign stop_hit = ok && ((rsel == 2'b10 && m_s1) || (rsel == 2'b01 && m_s2)
      || (rsel == 2'b11 && !seq && (m_s1 || m_s2)));
   assign res_hit = ok && ((rsel == 2'b10 && m_r1) || (rsel == 2'b01 && m_r2)
      || (rsel == 2'b11 && !seq && (m_r1 || m_r2)));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         halted_r <= 1'b0;
         flag_r <= 1'b0;
         flag_special_r <= 1'b0;
         pend_r <= 1'b0;
         pend_stop_r <= 1'b0;
         pend_c_r <= '0;
         hold_v_r <= 1'b0;
         hold_c_r <= '0;
         rxw_valid_r <= 1'b0;
         rxw_r <= '0;
      end
      else
      begin
         rxw_valid_r <= 1'b0;
         hold_v_r <= 1'b0;
         // RULE8 ident read clears a special-character flag; a set below wins
         if (iir_rd && flag_special_r)
            flag_r <= 1'b0;
         if (rsel == 2'b00)
            halted_r <= 1'b0;
         if (in_v)
         begin
            if (pend_r)
            begin
               pend_r <= 1'b0;
               if (ok && (pend_stop_r ? m_s2 : m_r2))
               begin
                  halted_r <= pend_stop_r;
                  flag_r <= pend_stop_r;
                  flag_special_r <= 1'b0;
               end
               else
               begin
                  // RULE15 broken pair: first char goes in as data
                  rxw_valid_r <= 1'b1;
                  rxw_r <= pend_c_r;
                  hold_v_r <= 1'b1;
                  hold_c_r <= in_c;
               end
            end
            // RULE9 stop halts the next start, flags
            else if (stop_hit)
            begin
               halted_r <= 1'b1;
               flag_r <= 1'b1;
               flag_special_r <= 1'b0;
            end
            // RULE10 resume
            else if (res_hit)
            begin
               halted_r <= 1'b0;
               flag_r <= 1'b0;
            end
            else if (ok && seq && (m_s1 || m_r1))
            begin
               pend_r <= 1'b1;
               pend_stop_r <= m_s1;
               pend_c_r <= in_c;
            end
            else
            begin
               rxw_valid_r <= 1'b1;
               rxw_r <= in_c;
               // RULE7 any character resumes
               if (modem_control_reg_r[MCR_XON_ANY] && halted_r)
               begin
                  halted_r <= 1'b0;
                  flag_r <= 1'b0;
               end
               // RULE8 special character flags without halting
               if (enhanced_feature_reg_r[EFR_SPECIAL] && ok && m_s2)
               begin
                  flag_r <= 1'b1;
                  flag_special_r <= 1'b1;
               end
            end
         end
      end
   end

   // RULE22 pin states
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tx_out_r <= 1'b1;
         rts_n_r <= 1'b1;
         dtr_n_r <= 1'b1;
         rx_rdy_n_r <= 1'b1;
         tx_rdy_n_r <= 1'b0;
         int_out_r <= 1'b0;
      end
      else
      begin
         tx_out_r <= line_r && !line_control_reg_r[LCR_BREAK];
         rts_n_r <= !modem_control_reg_r[MCR_RTS];
         dtr_n_r <= !modem_control_reg_r[MCR_DTR];
         rx_rdy_n_r <= rx_level == '0;
         tx_rdy_n_r <= txf_full;
         // RULE9 interrupt when enabled
         int_out_r <= flag_r && interrupt_enable_reg_r[IER_XOFF];
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign txf_take = txf_take_r;
   assign rxw_valid = rxw_valid_r;
   assign rxw = rxw_r;
   assign tx_out = tx_out_r;
   assign rts_n = rts_n_r;
   assign dtr_n = dtr_n_r;
   assign receive_ready_out_n = rx_rdy_n_r;
   assign transmit_ready_out_n = tx_rdy_n_r;
   assign int_out = int_out_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence stop_seen_s;
      in_v && !pend_r && stop_hit;
   endsequence
   sequence halt_flag_s;
      halted_r && flag_r;
   endsequence

   stop_halts_a: assert property (stop_seen_s |=> halt_flag_s) // RULE9
      else $error("stop character did not halt");
   stop_int_a: assert property ((stop_seen_s and interrupt_enable_reg_r[IER_XOFF]) // RULE9
      |=> ##1 int_out)
      else $error("interrupt not raised on stop");
   resume_clears_a: assert property (in_v && !pend_r && !stop_hit && res_hit
      |=> !halted_r && !flag_r) // RULE10
      else $error("resume did not clear halt");
   cts_gate_a: assert property (txf_take_r && enhanced_feature_reg_r[EFR_AUTO_CTS]
      |-> !$past(cts_n)) // RULE2
      else $error("character started while cts inactive");
   halted_no_data_a: assert property (halted_r && state_r == TX_IDLE |=> !txf_take_r) // RULE9
      else $error("data sent while halted");
   err_char_a: assert property (in_v && !pend_r && in_c.err
      |=> rxw_valid_r && !halted_r == !$past(halted_r) || rxw_valid_r) // RULE11
      else $error("erroneous character not stored");
   reset_regs_a: assert property (@(posedge clk) disable iff (1'b0) rst |=> line_control_reg_r
      == LCR_RST && !flag_r && interrupt_enable_reg_r == 8'h00) // RULE18
      else $error("register reset value wrong");
   reset_pins_a: assert property (@(posedge clk) disable iff (1'b0) rst |=> tx_out && rts_n
      && dtr_n && receive_ready_out_n && !transmit_ready_out_n) // RULE22
      else $error("pin reset state wrong");
   stop_send_a: assert property (!flow_busy_r && !xoff_sent_r && tsel != 2'b00
      && rx_level > halt_lvl |=> flow_busy_r && !flow_res_r && xoff_sent_r) // RULE12
      else $error("stop characters not queued");
   mode_change_a: assert property (!flow_busy_r && xoff_sent_r && tsel != sent_sel_r
      |=> flow_busy_r && flow_res_r && flow_sel_r == $past(sent_sel_r)) // RULE14
      else $error("original resume not queued");
   special_a: assert property (in_v && !pend_r && !stop_hit && !res_hit && !(ok && seq
      && (m_s1 || m_r1)) && enhanced_feature_reg_r[EFR_SPECIAL] && ok && m_s2
      |=> flag_r && rxw_valid_r) // RULE8
      else $error("special character not flagged");
endmodule : uart_flow_ctl

// ===== uart_remote_model.sv
`timescale 1ns/1ns
module uart_remote_model
   import uart_flow_pkg::*;
#(
   parameter int BC = 4
)
(
   // clock
   input wire logic clk,
   // serial line from the block
   input wire logic tx_out,
   // characters offered to the block
   output logic rxc_valid,
   output rx_char_t rxc,
   // decoded frames
   output logic [7:0] got_byte,
   output int got_cnt
);
   logic [7:0] sh;
   initial
   begin
      rxc_valid = 1'b0;
      rxc = '0;
      got_byte = 8'h00;
      got_cnt = 0;
   end
   // mid-bit sampling of 8n1 frames, lsb first
   always
   begin
      @(negedge tx_out);
      repeat (BC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BC) @(posedge clk);
         sh[i] = tx_out;
      end
      repeat (BC) @(posedge clk);
      got_byte <= sh;
      got_cnt <= got_cnt + 1;
   end
   task automatic offer(input rx_char_t c);
      @(posedge clk);
      rxc_valid <= 1'b1;
      rxc <= c;
      @(posedge clk);
      rxc_valid <= 1'b0;
      // stale bits scrambled so nothing relies on a held value
      rxc <= ~c;
      repeat (2) @(posedge clk);
   endtask : offer
endmodule : uart_remote_model

// ===== uart_flow_control_and_reset_tb_top.sv
`timescale 1ns/1ns
module uart_flow_control_and_reset_tb_top;
   import uart_flow_pkg::*;
   localparam int BC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psp = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic txf_take;
   logic rxc_valid;
   rx_char_t rxc;
   logic [6:0] rx_level = 7'h00;
   logic rxw_valid;
   rx_char_t rxw;
   rx_char_t w_last = '0;
   logic cts_n = 1'b0;
   logic txf_full = 1'b0;
   logic tx_out, rts_n, dtr_n, rr_n, tr_n, int_out;
   logic [7:0] got_byte;
   int got_cnt;
   int tx_cnt = 0;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic er;
   logic [7:0] ra [9] = '{OFF_IIR, OFF_LCR, OFF_LSR, OFF_IER, OFF_FCR, OFF_TCR, OFF_TLR,
      OFF_MCR, OFF_EFR};
   logic [7:0] rv [9] = '{8'h01, 8'h1d, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80};

   always #5 clk = ~clk;

   uart_flow_ctl #(.LVL_W(7), .BIT_CYCLES(BC)) i_dut (.clk(clk), .rst(rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .txf_valid(tx_cnt != 0), .txf_data(8'h55),
      .txf_full(txf_full), .txf_take(txf_take), .rxc_valid(rxc_valid), .rxc(rxc),
      .rx_level(rx_level), .rxw_valid(rxw_valid), .rxw(rxw), .cts_n(cts_n), .dsr_n(1'b1),
      .ri_n(1'b1), .cd_n(1'b1), .prescale_select_pin(psp), .tx_out(tx_out), .rts_n(rts_n),
      .dtr_n(dtr_n), .receive_ready_out_n(rr_n), .transmit_ready_out_n(tr_n),
      .int_out(int_out));

   uart_remote_model #(.BC(BC)) i_far (.clk(clk), .tx_out(tx_out), .rxc_valid(rxc_valid),
      .rxc(rxc), .got_byte(got_byte), .got_cnt(got_cnt));

   always @(posedge clk)
   begin
      if (txf_take === 1'b1)
         tx_cnt <= tx_cnt - 1;
      if (rxw_valid === 1'b1)
         w_last <= rxw;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end

   task automatic test_done;
      if (error_cnt == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
      apb(1'b0, a, 8'h00);
      chk({24'h0, e}, rd, nm);
   endtask : rchk

   task automatic do_reset(input logic p);
      psp <= p;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'h1e, {27'h0, tx_out, rts_n, dtr_n, rr_n, tr_n}, "pins in reset");
      rst <= 1'b0;
   endtask : do_reset

   task automatic wait_frame(input logic [7:0] e, input string nm);
      int base;
      base = got_cnt;
      for (int i = 0; i < 300 && got_cnt == base; i++)
         @(posedge clk);
      chk(base + 1, got_cnt, "frame count");
      chk({24'h0, e}, {24'h0, got_byte}, nm);
   endtask : wait_frame

   initial
   begin
      do_reset(1'b0);
      for (int i = 0; i < 9; i++)
         rchk(ra[i], rv[i], "reset value");
      txf_full <= 1'b1;
      repeat (2) @(posedge clk);
      chk(1, {31'h0, tr_n}, "transmit ready");
      txf_full <= 1'b0;
      apb(1'b1, 8'h00, 8'h5a);
      chk(32'h1, {31'h0, er}, "unmapped error");
      apb(1'b1, OFF_SPR, 8'ha5);
      apb(1'b1, OFF_STOP1, 8'h13);
      apb(1'b1, OFF_RES1, 8'h11);
      do_reset(1'b1);
      rchk(OFF_EFR, 8'h00, "feature after reset");
      rchk(OFF_SPR, 8'ha5, "scratch kept");
      rchk(OFF_STOP1, 8'h13, "stop char kept");
      apb(1'b1, OFF_LCR, 8'h03);
      // hardware gating alone; never both schemes at once
      apb(1'b1, OFF_EFR, 8'h80);
      // remote deasserts while the line is idle
      cts_n <= 1'b1;
      tx_cnt <= 1;
      repeat (60) @(posedge clk);
      chk(0, got_cnt, "held by cts");
      cts_n <= 1'b0;
      wait_frame(8'h55, "cts resume");
      apb(1'b1, OFF_EFR, 8'h0a);
      apb(1'b1, OFF_IER, 8'h20);
      i_far.offer({1'b0, 8'h13});
      chk(1, {31'h0, int_out}, "int on stop");
      rchk(OFF_IIR, IIR_XOFF_CODE, "ident after stop");
      tx_cnt <= 1;
      repeat (60) @(posedge clk);
      chk(1, got_cnt, "halted");
      i_far.offer({1'b0, 8'h11});
      wait_frame(8'h55, "resumed");
      rchk(OFF_IIR, IIR_RST, "ident after resume");
      i_far.offer({1'b1, 8'h13});
      @(posedge clk);
      chk({23'h0, 9'h113}, {23'h0, w_last}, "errored stop stored");
      // halt above 8, resume at 4 or below
      apb(1'b1, OFF_TCR, 8'h12);
      rx_level <= 7'd9;
      wait_frame(8'h13, "stop sent");
      apb(1'b1, OFF_EFR, 8'h02);
      wait_frame(8'h11, "resume on disable");
      apb(1'b1, OFF_EFR, 8'h0a);
      wait_frame(8'h13, "stop again");
      rx_level <= 7'd3;
      wait_frame(8'h11, "resume sent");
      apb(1'b1, OFF_STOP2, 8'h1a);
      apb(1'b1, OFF_EFR, 8'h2a);
      i_far.offer({1'b0, 8'h1a});
      chk(1, {31'h0, int_out}, "int on special");
      @(posedge clk);
      chk({23'h0, 9'h01a}, {23'h0, w_last}, "special stored");
      rchk(OFF_IIR, IIR_XOFF_CODE, "ident on special");
      rchk(OFF_IIR, IIR_RST, "ident read clears");
      test_done();
   end
endmodule : uart_flow_control_and_reset_tb_top
